// >>> rtl/sce_device.sv
// Device end: decodes command bytes, echoes them, runs the command states
//
// Function
// - Vocab load: opcode, 4-byte length, data, echoed
// - Detectors suspended during vocab load
// - Too long vocab: bad argument, abort
// - Partly filled vocab block excluded from recording
// - Wipe erases all but bad/vocab blocks
// - Wipe accepted only in reset or idle
// - Host configures before wipe in reset
// - Play ends: completion event, attention low, idle
// - Play without message: invalid operation
// - Suspend pauses activity, state unchanged
// - Detectors stay active paused, playing, recording
// - Sleep from reset or idle powers down; next command resets detectors
// - Host services events before sleep
// - Record: tag, rate, runs until stop
// - Rate 0 PCM, 1-3 compressed rates
// - Memory full stops record, sets event
// - Message stamped with time and day
// - Caller info attached when enabled
// - Detector clear mask resets selected detectors
// - Host keeps reserved mask bits zero
// - Continue resumes suspended activity
// - Stop aborts command, returns to idle
`timescale 1ns/1ps
module sce_device
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  sce_link_if.device                link,
  input  wire logic                 caller_info_attach_param,
  input  wire logic [15:0]          time_stamp,
  input  wire logic                 bad_block_hit,
  output sce_pkg::sce_state_t       state,
  output logic                      paused,
  output logic      [7:0]           detectors_on,
  output logic      [7:0]           detector_reset,
  output logic                      flash_wr_valid,
  output logic      [7:0]           flash_wr_data,
  input  wire logic                 flash_wr_ready,
  output logic      [15:0]          vocab_blocks,
  output logic      [15:0]          msg_tag,
  output sce_pkg::sce_rate_t        rec_rate,
  output logic      [15:0]          rec_stamp,
  output logic                      rec_caller_info,
  output logic                      wipe_pulse,
  output logic      [1:0]           error_word,
  output logic      [1:0]           event_word,
  input  wire logic                 event_ack
);
  import sce_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    sce_state_t  st;
    logic        paused;
    logic        msg_defined;
    logic [2:0]  argc;
    logic [7:0]  opc;
    logic [31:0] len;
    logic [31:0] done;
    logic [15:0] vblk;
    logic [15:0] used;
    logic [15:0] play_cnt;
    logic [15:0] tag;
    sce_rate_t   rate;
    logic [15:0] stamp;
    logic        cid;
    logic [7:0]  det_rst;
    logic        wipe;
    logic        rv;
    logic [7:0]  rb;
    logic [1:0]  err;
    logic [1:0]  ev;
  } sce_dev_st_t;

  sce_dev_st_t s_r;
  sce_dev_st_t s_nxt;
  logic        take;
  logic        data_phase;
  logic        f_ready;
  logic [31:0] free_bytes;

  // Data bytes go to flash via the FIFO; a full FIFO stalls the link
  assign data_phase = (s_r.st == ST_VOCAB) && (s_r.argc == 3'd0);
  assign link.cmd_ready = data_phase ? f_ready : 1'b1;
  assign take = link.cmd_valid && link.cmd_ready;
  assign free_bytes = {16'h0000, NUM_BLOCKS - s_r.vblk} << BLK_SHIFT;

  sce_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo
  (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (link.cmd_valid && data_phase),
    .in_data   (link.cmd_byte),
    .in_ready  (f_ready),
    .out_valid (flash_wr_valid),
    .out_data  (flash_wr_data),
    .out_ready (flash_wr_ready)
  );

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rv = 1'b0;
    s_nxt.det_rst = 8'h00;
    s_nxt.wipe = 1'b0;
    if (event_ack)
      s_nxt.ev = 2'b00;
    if (take)
    begin
      s_nxt.rv = 1'b1;
      s_nxt.rb = link.cmd_byte;
      if (s_r.st == ST_SLEEP)
      begin
        s_nxt.det_rst = DET_ALL;
        s_nxt.st = ST_IDLE;
      end
      else if (s_r.argc != 3'd0)
      begin
        s_nxt.argc = s_r.argc - 3'd1;
        if (s_r.opc == OP_VOCAB)
        begin
          s_nxt.len = {s_r.len[23:0], link.cmd_byte};
          if (s_r.argc == 3'd1)
          begin
            if (s_nxt.len > free_bytes)
            begin
              s_nxt.err[ERR_BAD_ARG] = 1'b1;
              s_nxt.st = ST_IDLE;
            end
            else if (s_nxt.len == 32'h0)
              s_nxt.st = ST_IDLE;
          end
        end
        else if (s_r.opc == OP_RECORD)
        begin
          if (s_r.argc == 3'd1)
          begin
            s_nxt.rate = sce_rate_t'(link.cmd_byte[1:0]);
            s_nxt.st = ST_RECORD;
            s_nxt.stamp = time_stamp;
            s_nxt.cid = caller_info_attach_param;
            s_nxt.msg_defined = 1'b1;
          end
          else
            s_nxt.tag = {s_r.tag[7:0], link.cmd_byte};
        end
        else
          s_nxt.det_rst = link.cmd_byte & DCM_VALID;
      end
      else if (data_phase)
      begin
        s_nxt.done = s_r.done + 32'h1;
        if (s_nxt.done == s_r.len)
        begin
          // Round up: a block with any vocab byte is lost
          s_nxt.vblk = s_r.vblk + 16'((s_r.len + BLK_BYTES - 32'h1)
                       >> BLK_SHIFT);
          s_nxt.st = ST_IDLE;
        end
      end
      else
      begin
        s_nxt.opc = link.cmd_byte;
        unique case (link.cmd_byte)
          OP_STOP:
          begin
            s_nxt.st = ST_IDLE;
            s_nxt.paused = 1'b0;
          end
          OP_PLAY:
            if (!s_r.msg_defined)
              s_nxt.err[ERR_INVALID] = 1'b1;
            else
            begin
              s_nxt.st = ST_PLAY;
              s_nxt.play_cnt = PLAY_LEN;
              s_nxt.paused = 1'b0;
            end
          OP_RECORD:
          begin
            s_nxt.argc = 3'd3;
            s_nxt.paused = 1'b0;
          end
          OP_SLEEP:
            if (s_r.st == ST_IDLE || s_r.st == ST_RESET)
            begin
              s_nxt.st = ST_SLEEP;
              s_nxt.ev = 2'b00;
            end
          OP_SUSPEND:
            s_nxt.paused = 1'b1;
          OP_CONTINUE:
            s_nxt.paused = 1'b0;
          OP_VOCAB:
          begin
            s_nxt.st = ST_VOCAB;
            s_nxt.argc = 3'd4;
            s_nxt.len = 32'h0;
            s_nxt.done = 32'h0;
          end
          OP_WIPE:
            if (s_r.st == ST_IDLE || s_r.st == ST_RESET)
            begin
              // Vocab and bad blocks survive; recordings go
              s_nxt.wipe = 1'b1;
              s_nxt.used = 16'h0;
              s_nxt.msg_defined = 1'b0;
              s_nxt.st = ST_IDLE;
            end
          OP_DET_CLEAR:
            s_nxt.argc = 3'd1;
          default:
            s_nxt.opc = s_r.opc;
        endcase
      end
    end
    else if (s_r.st == ST_PLAY && !s_r.paused)
    begin
      s_nxt.play_cnt = s_r.play_cnt - 16'h1;
      if (s_r.play_cnt == 16'h1)
      begin
        s_nxt.ev[EV_COMPLETE] = 1'b1;
        s_nxt.st = ST_IDLE;
      end
    end
    else if (s_r.st == ST_RECORD && !s_r.paused && !bad_block_hit)
    begin
      s_nxt.used = s_r.used + 16'h1;
      if (s_r.used + 16'h1 + s_r.vblk >= NUM_BLOCKS)
      begin
        s_nxt.ev[EV_FULL] = 1'b1;
        s_nxt.st = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.reply_valid      = s_r.rv;
  assign link.reply_byte       = s_r.rb;
  assign link.host_attention_n = (s_r.ev == 2'b00);
  assign state           = s_r.st;
  assign paused          = s_r.paused;
  // Off only while loading vocab or asleep; pause keeps them on
  assign detectors_on    = (s_r.st == ST_VOCAB || s_r.st == ST_SLEEP)
                           ? 8'h00 : DET_ALL;
  assign detector_reset  = s_r.det_rst;
  assign vocab_blocks    = s_r.vblk;
  assign msg_tag         = s_r.tag;
  assign rec_rate        = s_r.rate;
  assign rec_stamp       = s_r.stamp;
  assign rec_caller_info = s_r.cid;
  assign wipe_pulse      = s_r.wipe;
  assign error_word      = s_r.err;
  assign event_word      = s_r.ev;
endmodule

// >>> rtl/sce_pkg.sv
// Shared constants and types for the speech command executor link
package sce_pkg;
  // --------------------------------------------------------------
  // Command opcodes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_STOP      = 8'h00;
  localparam logic [7:0] OP_PLAY      = 8'h03;
  localparam logic [7:0] OP_RECORD    = 8'h0c;
  localparam logic [7:0] OP_SLEEP     = 8'h1a;
  localparam logic [7:0] OP_SUSPEND   = 8'h1c;
  localparam logic [7:0] OP_CONTINUE  = 8'h1d;
  localparam logic [7:0] OP_VOCAB     = 8'h29;
  localparam logic [7:0] OP_WIPE      = 8'h2a;
  localparam logic [7:0] OP_DET_CLEAR = 8'h2c;

  // --------------------------------------------------------------
  // Detector clear mask bits and detector vector layout
  // --------------------------------------------------------------
  localparam int DCM_TONE   = 0;
  localparam int DCM_ENERGY = 4;
  localparam int DCM_VOX    = 5;
  localparam int DCM_DTMF   = 6;
  localparam logic [7:0] DCM_VALID = 8'h71;
  localparam logic [7:0] DET_ALL   = 8'h71;

  // --------------------------------------------------------------
  // Error and event word bits
  // --------------------------------------------------------------
  localparam int ERR_BAD_ARG = 0;
  localparam int ERR_INVALID = 1;
  localparam int EV_COMPLETE = 0;
  localparam int EV_FULL     = 1;

  // --------------------------------------------------------------
  // Storage geometry
  // --------------------------------------------------------------
  localparam int          BLK_SHIFT  = 12;
  localparam logic [31:0] BLK_BYTES  = 32'h0000_1000;
  localparam logic [15:0] NUM_BLOCKS = 16'h0100;
  localparam int          FIFO_W     = 8;
  localparam int          FIFO_D     = 16;
  localparam logic [15:0] PLAY_LEN   = 16'h0040;

  typedef enum logic [2:0]
  {
    ST_RESET  = 3'b000,
    ST_IDLE   = 3'b001,
    ST_PLAY   = 3'b010,
    ST_RECORD = 3'b011,
    ST_VOCAB  = 3'b100,
    ST_SLEEP  = 3'b101
  } sce_state_t;

  typedef enum logic [1:0]
  {
    RATE_PCM = 2'b00,
    RATE_4K7 = 2'b01,
    RATE_6K7 = 2'b10,
    RATE_8K7 = 2'b11
  } sce_rate_t;
endpackage

// >>> rtl/sce_link_if.sv
// Byte link joining the host end and the device end
`timescale 1ns/1ps
interface sce_link_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       cmd_ready;
  logic       reply_valid;
  logic [7:0] reply_byte;
  logic       host_attention_n;

  modport host
  (
    output cmd_valid,
    output cmd_byte,
    input  cmd_ready,
    input  reply_valid,
    input  reply_byte,
    input  host_attention_n
  );

  modport device
  (
    input  cmd_valid,
    input  cmd_byte,
    output cmd_ready,
    output reply_valid,
    output reply_byte,
    output host_attention_n
  );
endinterface

// >>> rtl/sce_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } sce_fifo_st_t;

  sce_fifo_st_t s_r;
  sce_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// >>> rtl/sce_host.sv
// Host end: sends queued command bytes and collects echoes
`timescale 1ns/1ps
module sce_host
(
  input  wire logic       clk,
  input  wire logic       rst,
  sce_link_if.host        link,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            attention
);
  import sce_pkg::*;

  // ----------------------------------------------------------------
  // Byte holder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       full;
    logic [7:0] b;
    logic       rv;
    logic [7:0] rb;
  } sce_host_st_t;

  sce_host_st_t s_r;
  sce_host_st_t s_nxt;

  // Caller keeps reserved clear-mask bits zero and configures first
  assign tx_ready       = !s_r.full || link.cmd_ready;
  assign link.cmd_valid = s_r.full;
  assign link.cmd_byte  = s_r.b;
  assign rx_valid       = s_r.rv;
  assign rx_byte        = s_r.rb;
  assign attention      = !link.host_attention_n;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rv = link.reply_valid;
    if (link.reply_valid)
      s_nxt.rb = link.reply_byte;
    if (s_r.full && link.cmd_ready)
      s_nxt.full = 1'b0;
    if (tx_valid && tx_ready)
    begin
      s_nxt.full = 1'b1;
      s_nxt.b = tx_byte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// >>> bench/sce_props.sv
// Assertion checker for the command byte link
`timescale 1ns/1ps
module sce_props
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_ready,
  input wire logic       reply_valid,
  input wire logic [7:0] reply_byte,
  input wire logic       host_attention_n
);
  import sce_pkg::*;
  // ----------
  // Byte parser
  // ----------
  logic [2:0]  hdr_r;
  logic [31:0] len_r;
  logic [31:0] data_r;
  logic        vocab_r;
  logic        asleep_r;
  logic        take;
  logic        op;
  assign take = cmd_valid & cmd_ready;
  assign op   = take & (data_r == 32'h0) & (hdr_r == 3'h0) & !asleep_r;
  // An aborted over-long load is not seen here; the op-gated and ready checks go quiet
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hdr_r    <= 3'h0;
      len_r    <= 32'h0;
      data_r   <= 32'h0;
      vocab_r  <= 1'b0;
      asleep_r <= 1'b0;
    end
    else if (take)
    begin
      if (data_r != 32'h0)
        data_r <= data_r - 32'h1;
      else if (hdr_r != 3'h0)
      begin
        hdr_r <= hdr_r - 3'h1;
        len_r <= {len_r[23:0], cmd_byte};
        if (vocab_r && hdr_r == 3'h1)
        begin
          data_r  <= {len_r[23:0], cmd_byte};
          vocab_r <= 1'b0;
        end
      end
      else if (asleep_r)
        asleep_r <= 1'b0;
      else
      begin
        hdr_r    <= (cmd_byte == OP_VOCAB) ? 3'h4 :
                    (cmd_byte == OP_RECORD) ? 3'h3 :
                    (cmd_byte == OP_DET_CLEAR) ? 3'h1 : 3'h0;
        vocab_r  <= (cmd_byte == OP_VOCAB);
        asleep_r <= (cmd_byte == OP_SLEEP);
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_echo_valid; take |=> reply_valid; endproperty
  a_echo_valid: assert property (p_echo_valid)
    else $error("reply missing");
  property p_echo_byte; take |=> reply_byte == $past(cmd_byte); endproperty
  a_echo_byte: assert property (p_echo_byte)
    else $error("reply byte wrong");
  property p_reply_cause; reply_valid |-> $past(take); endproperty
  a_reply_cause: assert property (p_reply_cause)
    else $error("reply without byte");
  property p_ready_cmd; data_r == 32'h0 |-> cmd_ready; endproperty
  a_ready_cmd: assert property (p_ready_cmd)
    else $error("command byte refused");
  property p_sleep_drop;
    op && cmd_byte == OP_SLEEP |-> ##[1:3] host_attention_n; endproperty
  a_sleep_drop: assert property (p_sleep_drop)
    else $error("event kept in sleep");
  property p_wake; asleep_r && take |=> host_attention_n [*4]; endproperty
  a_wake: assert property (p_wake)
    else $error("wake byte raised event");
  property p_play_quiet; op && cmd_byte == OP_PLAY && host_attention_n
    |=> host_attention_n [*8]; endproperty
  a_play_quiet: assert property (p_play_quiet)
    else $error("play ended too soon");
  property p_stop_quiet; op && cmd_byte == OP_STOP && host_attention_n
    |=> host_attention_n [*3]; endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("stop raised event");
endmodule

// >>> bench/speech_command_executor_tb_top.sv
// Testbench joining host and device ends over the byte link
`timescale 1ns/1ps
module speech_command_executor_tb_top;
  import sce_pkg::*;
  // ----------
  // Signals and rows
  // ----------
  typedef struct packed
  {
    logic [31:0] b;
    int          n;
    sce_state_t  st;
    sce_rate_t   rt;
    logic        pz;
  } sce_row_t;
  localparam logic [31:0] VLEN = 32'h0000_1064;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_byte = 8'h00;
  logic        flash_wr_ready = 1'b0;
  logic        event_ack = 1'b0;
  logic        cid_en = 1'b0;
  logic [15:0] tstamp = 16'h0000;
  logic        clr_seen = 1'b0;
  logic [7:0]  det_seen = 8'h00;
  logic        wipe_seen = 1'b0;
  logic [15:0] wr_cnt = 16'h0000;
  logic [15:0] wr_bad = 16'h0000;
  logic [2:0]  cyc = 3'h0;
  int          err_total = 0;
  int          comparisons = 0;
  logic        tx_ready, rx_valid, attention, paused, flash_wr_valid;
  logic        rec_caller_info, wipe_pulse;
  logic [7:0]  rx_byte, detectors_on, detector_reset, flash_wr_data;
  logic [15:0] vocab_blocks, msg_tag, rec_stamp;
  logic [1:0]  error_word, event_word;
  sce_state_t  state;
  sce_rate_t   rec_rate;
  sce_row_t    rows [15] = '{
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0},
    '{32'h0c12_3400,4,ST_RECORD,RATE_PCM,1'b0},
    '{32'h1c00_0000,1,ST_RECORD,RATE_PCM,1'b1},
    '{32'h1d00_0000,1,ST_RECORD,RATE_PCM,1'b0},
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0},
    '{32'h0c00_0101,4,ST_RECORD,RATE_4K7,1'b0},
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0},
    '{32'h0c00_0202,4,ST_RECORD,RATE_6K7,1'b0},
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0},
    '{32'h0c00_0e03,4,ST_RECORD,RATE_8K7,1'b0},
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0},
    '{32'h0300_0000,1,ST_PLAY,RATE_PCM,1'b0},
    '{32'h1c00_0000,1,ST_PLAY,RATE_PCM,1'b1},
    '{32'h1d00_0000,1,ST_PLAY,RATE_PCM,1'b0},
    '{32'h0000_0000,1,ST_IDLE,RATE_PCM,1'b0}};
  always #20 clk = ~clk;
  sce_link_if link ();
  sce_host u_sce_host (.clk, .rst, .link(link), .tx_valid, .tx_byte,
    .tx_ready, .rx_valid, .rx_byte, .attention);
  sce_device u_sce_device (.clk, .rst, .link(link),
    .caller_info_attach_param(cid_en), .time_stamp(tstamp),
    .bad_block_hit(1'b0), .state, .paused, .detectors_on, .detector_reset,
    .flash_wr_valid, .flash_wr_data, .flash_wr_ready, .vocab_blocks,
    .msg_tag, .rec_rate, .rec_stamp, .rec_caller_info, .wipe_pulse,
    .error_word, .event_word, .event_ack);
  sce_props u_sce_props (.clk, .rst, .cmd_valid(link.cmd_valid),
    .cmd_byte(link.cmd_byte), .cmd_ready(link.cmd_ready),
    .reply_valid(link.reply_valid), .reply_byte(link.reply_byte),
    .host_attention_n(link.host_attention_n));
  // Flash takes one byte in eight so the FIFO fills and refuses
  always @(posedge clk)
  begin
    cyc <= cyc + 3'h1;
    flash_wr_ready <= (cyc == 3'h0);
    det_seen <= clr_seen ? 8'h00 : (det_seen | detector_reset);
    wipe_seen <= clr_seen ? 1'b0 : (wipe_seen | wipe_pulse);
    if (flash_wr_valid && flash_wr_ready)
    begin
      wr_cnt <= wr_cnt + 16'h1;
      if (flash_wr_data !== wr_cnt[7:0])
        wr_bad <= wr_bad + 16'h1;
    end
  end
  task automatic results;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input logic sel, input int lim);
    int k = 0;
    while ((sel ? attention : rx_valid) !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    if ((sel ? attention : rx_valid) !== 1'b1)
    begin
      err_total++;
      results();
    end
  endtask
  task automatic send(input logic [7:0] b);
    int k = 0;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_byte <= b;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (tx_ready !== 1'b1 && k < 300);
    if (tx_ready !== 1'b1)
    begin
      err_total++;
      results();
    end
    @(posedge clk);
    tx_valid <= 1'b0;
    wt(1'b0, 20);
    chk(16'(rx_byte), 16'(b));
  endtask
  task automatic send32(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      send(v[31 - 8 * i -: 8]);
  endtask
  task automatic clr;
    @(posedge clk);
    clr_seen <= 1'b1;
    @(posedge clk);
    clr_seen <= 1'b0;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    send(OP_PLAY);
    chk(16'(error_word), 16'h0002);
    for (int i = 0; i < 15; i++)
    begin
      @(posedge clk);
      cid_en <= rows[i].rt[0];
      tstamp <= rows[i].b[15:0];
      for (int j = 0; j < rows[i].n; j++)
        send(rows[i].b[31 - 8 * j -: 8]);
      // Stamp must be held from the rate byte, not followed live
      @(posedge clk);
      tstamp <= 16'h0000;
      @(negedge clk);
      chk(16'(state), 16'(rows[i].st));
      chk(16'(paused), 16'(rows[i].pz));
      if (rows[i].st != ST_IDLE)
        chk(16'(detectors_on), 16'(DET_ALL));
      // Only the row that opened the recording carries tag and rate
      if (rows[i].n == 4)
      begin
        chk(msg_tag, rows[i].b[23:8]);
        chk(16'(rec_rate), 16'(rows[i].rt));
        chk(rec_stamp, rows[i].b[15:0]);
        chk(16'(rec_caller_info), 16'(rows[i].rt[0]));
      end
    end
    send(OP_PLAY);
    wt(1'b1, 200);
    chk(16'(event_word), 16'h0001);
    chk(16'(state), 16'(ST_IDLE));
    send(OP_SLEEP);
    repeat (3) @(negedge clk);
    chk(16'(attention), 16'h0000);
    chk(16'(state), 16'(ST_SLEEP));
    clr();
    send(OP_PLAY);
    chk(16'(state), 16'(ST_IDLE));
    chk(16'(det_seen), 16'(DET_ALL));
    for (int i = 0; i < 8; i++)
      if (DCM_VALID[i])
      begin
        clr();
        send(OP_DET_CLEAR);
        send(8'h01 << i);
        chk(16'(det_seen), 16'(8'h01 << i));
      end
    send(OP_VOCAB);
    send32(VLEN);
    for (int i = 0; i < int'(VLEN); i++)
    begin
      send(8'(i));
      if (i == 100)
        chk(16'(detectors_on), 16'h0000);
    end
    for (int k = 0; k < 300 && wr_cnt != VLEN[15:0]; k++)
      @(negedge clk);
    chk(wr_cnt, VLEN[15:0]);
    if (wr_cnt !== VLEN[15:0])
      results();
    chk(wr_bad, 16'h0000);
    chk(vocab_blocks, 16'h0002);
    clr();
    send(OP_WIPE);
    chk(16'(wipe_seen), 16'h0001);
    chk(vocab_blocks, 16'h0002);
    send32(32'h0c00_0501);
    clr();
    send(OP_WIPE);
    chk(16'(wipe_seen), 16'h0000);
    wt(1'b1, 600);
    chk(16'(event_word), 16'h0002);
    chk(16'(state), 16'(ST_IDLE));
    @(posedge clk);
    event_ack <= 1'b1;
    @(posedge clk);
    event_ack <= 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(attention), 16'h0000);
    send(OP_VOCAB);
    send32(32'h0010_0001);
    repeat (2) @(negedge clk);
    chk(16'(error_word), 16'h0003);
    chk(16'(state), 16'(ST_IDLE));
    // Mid-run reset: sticky flags clear and the message is forgotten
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    send(OP_PLAY);
    chk(16'(error_word), 16'h0002);
    chk(16'(state), 16'(ST_RESET));
    send(8'h7f);
    chk(16'(state), 16'(ST_RESET));
    send(OP_VOCAB);
    send32(32'h0000_0000);
    chk(16'(state), 16'(ST_IDLE));
    chk(vocab_blocks, 16'h0000);
    results();
  end
endmodule
